// [core/ufi_pkg.sv]
package ufi_pkg;
  // ********************************************************
  // register byte offsets
  // ********************************************************
  localparam logic [4:0] OFS_DATA = 5'h00;
  localparam logic [4:0] OFS_IEN  = 5'h04;
  localparam logic [4:0] OFS_IDF  = 5'h08;
  localparam logic [4:0] OFS_LINE = 5'h14;
  localparam logic [4:0] OFS_MDM  = 5'h18;
  // ********************************************************
  // field positions
  // ********************************************************
  localparam int IEN_RX    = 0;
  localparam int IEN_TX    = 1;
  localparam int IEN_LINE  = 2;
  localparam int IEN_MDM   = 3;
  localparam int FSR_EN    = 0;
  localparam int FSR_RXCLR = 1;
  localparam int FSR_TXCLR = 2;
  localparam int FSR_TRGLO = 6;
  localparam int FSR_TRGHI = 7;
  // ********************************************************
  // reset values and identification codes
  // ********************************************************
  localparam logic [3:0] IEN_RST   = 4'h0;
  localparam logic [1:0] TRG_RST   = 2'h0;
  localparam logic [3:0] IDF_NONE  = 4'h1;
  localparam logic [3:0] IDF_LINE  = 4'h6;
  localparam logic [3:0] IDF_RXAV  = 4'h4;
  localparam logic [3:0] IDF_CTO   = 4'hC;
  localparam logic [3:0] IDF_TX_HOLDING_EMPTY  = 4'h2;
  localparam logic [3:0] IDF_MDM   = 4'h0;
  // ********************************************************
  // trigger levels in bytes
  // ********************************************************
  localparam logic [4:0] TRG_L0 = 5'h01;
  localparam logic [4:0] TRG_L1 = 5'h04;
  localparam logic [4:0] TRG_L2 = 5'h08;
  localparam logic [4:0] TRG_L3 = 5'h0E;
  // ********************************************************
  // timing
  // ********************************************************
  localparam int          CNT_W        = 5;
  localparam int          TICK_W       = 9;
  localparam logic [8:0]  TICKS_BIT    = 9'h010;
  localparam logic [8:0]  TICKS_HALF   = 9'h008;
  localparam logic [8:0]  BITS_BASE    = 9'h007;
  localparam logic [2:0]  TO_CHARS     = 3'h4;
  localparam logic [2:0]  TXD_CHARS    = 3'h1;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } ufi_bus_t;
endpackage

// [core/ufi_char_timer.sv]
`timescale 1ns/1ns
module ufi_char_timer
  import ufi_pkg::*;
#(
  parameter int TW = 9,
  parameter int NW = 3
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          run,
  input  wire logic          restart,
  input  wire logic          tick,
  input  wire logic [TW-1:0] ticks_per_char,
  input  wire logic [NW-1:0] n_chars,
  output logic               expired
);
  logic [TW-1:0] tcnt;
  logic [NW-1:0] ccnt;

  // counts baud ticks into whole character times
  always_ff @(posedge clk) begin
    if (!rst_b || restart || !run) begin
      tcnt    <= '0;
      ccnt    <= '0;
      expired <= 1'b0;
    end else if (tick && !expired) begin
      if (tcnt == ticks_per_char - TW'(1)) begin
        tcnt <= '0;
        if (ccnt == n_chars - NW'(1)) begin
          expired <= 1'b1;
        end else begin
          ccnt <= ccnt + NW'(1);
        end
      end else begin
        tcnt <= tcnt + TW'(1);
      end
    end
  end
endmodule

// [core/ufi_core.sv]
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
module ufi_core
  import ufi_pkg::*;
#(
  parameter int CW = CNT_W
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic [4:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  input  wire logic [3:0]    avs_byteenable,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  input  wire logic [CW-1:0] rx_count,
  input  wire logic [7:0]    rx_data,
  input  wire logic          rx_push,
  input  wire logic [3:0]    rx_err_event,
  input  wire logic          rx_fifo_error,
  input  wire logic          rclk_tick,
  input  wire logic [CW-1:0] tx_count,
  input  wire logic          tx_shift_empty,
  input  wire logic          tx_tick,
  input  wire logic [1:0]    word_len,
  input  wire logic          two_stop,
  input  wire logic          parity_en,
  input  wire logic [3:0]    modem_pins,
  output logic               rx_pop,
  output logic               tx_push,
  output logic [7:0]         tx_data,
  output logic               fifo_enable_bit,
  output logic [1:0]         trigger_level,
  output logic               rx_fifo_clear,
  output logic               tx_fifo_clear,
  output logic               interrupt_output
);
  // ********************************************************
  // avalon slave
  // ********************************************************
  ufi_bus_t   bus;
  logic       acc;
  logic       acc_rd;
  logic       acc_wr;
  logic [7:0] wd;
  logic [7:0] next_rdata;
  logic [3:0] interrupt_enable;
  logic [7:0] interrupt_identification;
  logic [7:0] line_state_reg;
  logic [7:0] modem_state_reg;

  assign acc             = (bus == BUS_ACK);
  assign avs_waitrequest = (avs_read || avs_write) && !acc;
  assign acc_rd          = acc && avs_read;
  assign acc_wr          = acc && avs_write && avs_byteenable[0];
  assign wd              = avs_writedata[7:0];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bus <= BUS_IDLE;
    end else begin
      case (bus)
        BUS_IDLE: if (avs_read || avs_write) bus <= BUS_ACK;
        BUS_ACK:  bus <= BUS_IDLE;
        default:  bus <= BUS_IDLE;
      endcase
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (avs_address == OFS_DATA) begin
      next_rdata = rx_data;
    end else if (avs_address == OFS_IEN) begin
      next_rdata = {4'h0, interrupt_enable};
    end else if (avs_address == OFS_IDF) begin
      next_rdata = interrupt_identification;
    end else if (avs_address == OFS_LINE) begin
      next_rdata = line_state_reg;
    end else if (avs_address == OFS_MDM) begin
      next_rdata = modem_state_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !acc) begin
      avs_readdata <= {24'h00_0000, next_rdata};
    end
  end

  // ********************************************************
  // register access strobes
  // ********************************************************
  logic rd_data;
  logic rd_idf;
  logic rd_line;
  logic rd_mdm;

  assign rd_data = acc_rd && (avs_address == OFS_DATA);
  assign rd_idf  = acc_rd && (avs_address == OFS_IDF);
  assign rd_line = acc_rd && (avs_address == OFS_LINE);
  assign rd_mdm  = acc_rd && (avs_address == OFS_MDM);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_pop  <= 1'b0;
      tx_push <= 1'b0;
      tx_data <= 8'h00;
    end else begin
      rx_pop  <= rd_data && (rx_count != '0);
      tx_push <= acc_wr && (avs_address == OFS_DATA);
      if (acc_wr && (avs_address == OFS_DATA)) tx_data <= wd;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      interrupt_enable <= IEN_RST;
    end else if (acc_wr && (avs_address == OFS_IEN)) begin
      interrupt_enable <= wd[3:0];
    end
  end

  // ********************************************************
  // fifo setup register
  // ********************************************************
  logic fen_changed;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fifo_enable_bit <= 1'b0;
      trigger_level   <= TRG_RST;
      rx_fifo_clear   <= 1'b0;
      tx_fifo_clear   <= 1'b0;
    end else begin
      rx_fifo_clear <= 1'b0;
      tx_fifo_clear <= 1'b0;
      if (acc_wr && (avs_address == OFS_IDF)) begin
        fifo_enable_bit <= wd[FSR_EN];
        if (wd[FSR_EN]) trigger_level <= wd[FSR_TRGHI:FSR_TRGLO];
        rx_fifo_clear <= (wd[FSR_EN] && wd[FSR_RXCLR]) || fen_changed;
        tx_fifo_clear <= (wd[FSR_EN] && wd[FSR_TXCLR]) || fen_changed;
      end
    end
  end

  assign fen_changed = wd[FSR_EN] != fifo_enable_bit;

  // ********************************************************
  // receive data and timeout
  // ********************************************************
  logic [4:0]        trig_bytes;
  logic              rx_avail;
  logic              to_run;
  logic              to_pend;
  logic [TICK_W-1:0] rx_char_ticks;
  logic [TICK_W-1:0] stop2_ticks;

  always_comb begin
    case (trigger_level)
      2'h0:    trig_bytes = TRG_L0;
      2'h1:    trig_bytes = TRG_L1;
      2'h2:    trig_bytes = TRG_L2;
      default: trig_bytes = TRG_L3;
    endcase
  end

  assign rx_avail = fifo_enable_bit ?
                    (CW'(trig_bytes) <= rx_count) : (rx_count != '0);

  assign stop2_ticks = !two_stop ? '0 :
                       (word_len == 2'h0) ? TICKS_HALF : TICKS_BIT;
  assign rx_char_ticks = TICK_W'((BITS_BASE + TICK_W'(word_len)
                         + TICK_W'(parity_en)) * TICKS_BIT) + stop2_ticks;

  assign to_run = fifo_enable_bit && interrupt_enable[IEN_RX]
                  && (rx_count != '0);

  ufi_char_timer #(.TW(TICK_W), .NW(3)) u_rx_timeout (
    .clk            (clk),
    .rst_b          (rst_b),
    .run            (to_run),
    .restart        (rx_push || rx_pop),
    .tick           (rclk_tick),
    .ticks_per_char (rx_char_ticks),
    .n_chars        (TO_CHARS),
    .expired        (to_pend)
  );

  // ********************************************************
  // transmit empty and delay
  // ********************************************************
  logic              tx_empty;
  logic              tx_seen2;
  logic              first_imm;
  logic              tx_holding_empty_ready;
  logic              tx_holding_empty_ready_q;
  logic              tx_delay_done;
  logic              tx_holding_empty_int;
  logic              tx_holding_empty_set;
  logic              tx_holding_empty_clr;
  logic              ien_tx_q;
  logic [TICK_W-1:0] tx_delay_ticks;

  assign tx_empty = (tx_count == '0);

  assign tx_delay_ticks = rx_char_ticks - TICKS_BIT;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_seen2 <= 1'b0;
    end else if (tx_count >= CW'(2)) begin
      tx_seen2 <= 1'b1;
    end else if (tx_holding_empty_ready) begin
      tx_seen2 <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      first_imm <= 1'b1;
    end else if (acc_wr && (avs_address == OFS_IDF) && fen_changed) begin
      first_imm <= 1'b1;
    end else if (tx_holding_empty_ready) begin
      first_imm <= 1'b0;
    end
  end

  ufi_char_timer #(.TW(TICK_W), .NW(3)) u_tx_delay (
    .clk            (clk),
    .rst_b          (rst_b),
    .run            (tx_empty),
    .restart        (1'b0),
    .tick           (tx_tick),
    .ticks_per_char (tx_delay_ticks),
    .n_chars        (TXD_CHARS),
    .expired        (tx_delay_done)
  );

  // once up, ready holds until the fifo takes a byte
  assign tx_holding_empty_ready = tx_empty && (!fifo_enable_bit || tx_seen2
                      || first_imm || tx_delay_done || tx_holding_empty_ready_q);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_holding_empty_ready_q <= 1'b0;
      ien_tx_q     <= 1'b0;
    end else begin
      tx_holding_empty_ready_q <= tx_holding_empty_ready;
      ien_tx_q     <= interrupt_enable[IEN_TX];
    end
  end

  assign tx_holding_empty_set = tx_holding_empty_ready && (!tx_holding_empty_ready_q || first_imm
                    || (interrupt_enable[IEN_TX] && !ien_tx_q));
  assign tx_holding_empty_clr = tx_push || (rd_idf && interrupt_identification[3:0]
                    == IDF_TX_HOLDING_EMPTY) || !tx_empty;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_holding_empty_int <= 1'b0;
    end else if (tx_holding_empty_set) begin
      tx_holding_empty_int <= 1'b1;
    end else if (tx_holding_empty_clr) begin
      tx_holding_empty_int <= 1'b0;
    end
  end

  // ********************************************************
  // line and modem status
  // ********************************************************
  logic [3:0] line_err;
  logic [3:0] mdm_s1;
  logic [3:0] mdm_s2;
  logic [3:0] mdm_q;
  logic [3:0] mdm_delta;
  logic [3:0] mdm_evt;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      line_err <= 4'h0;
    end else begin
      line_err <= rx_err_event | (rd_line ? 4'h0 : line_err);
    end
  end

  // shifts through reset so idle pins give no false delta
  always_ff @(posedge clk) begin
    mdm_s1 <= modem_pins;
    mdm_s2 <= mdm_s1;
    mdm_q  <= mdm_s2;
  end

  // bit 2 is ring: only its trailing edge counts
  assign mdm_evt = {mdm_q[3] ^ mdm_s2[3], mdm_q[2] & ~mdm_s2[2],
                    mdm_q[1:0] ^ mdm_s2[1:0]};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mdm_delta <= 4'h0;
    end else begin
      mdm_delta <= mdm_evt | (rd_mdm ? 4'h0 : mdm_delta);
    end
  end

  assign line_state_reg = {fifo_enable_bit && rx_fifo_error,
                           tx_empty && tx_shift_empty, tx_empty,
                           line_err, rx_count != '0};
  assign modem_state_reg = {mdm_s2, mdm_delta};

  // ********************************************************
  // priority and identification
  // ********************************************************
  logic       p_line;
  logic       p_rx;
  logic       p_to;
  logic       p_tx;
  logic       p_mdm;
  logic       any_pend;
  logic [3:0] idf_code;

  assign p_line   = interrupt_enable[IEN_LINE] && (line_err != 4'h0);
  assign p_rx     = interrupt_enable[IEN_RX] && rx_avail;
  assign p_to     = interrupt_enable[IEN_RX] && to_pend;
  assign p_tx     = interrupt_enable[IEN_TX] && tx_holding_empty_int;
  assign p_mdm    = interrupt_enable[IEN_MDM] && (mdm_delta != 4'h0);
  assign any_pend = p_line || p_rx || p_to || p_tx || p_mdm;

  always_comb begin
    if (p_line) begin
      idf_code = IDF_LINE;
    end else if (p_rx) begin
      idf_code = IDF_RXAV;
    end else if (p_to) begin
      idf_code = IDF_CTO;
    end else if (p_tx) begin
      idf_code = IDF_TX_HOLDING_EMPTY;
    end else if (p_mdm) begin
      idf_code = IDF_MDM;
    end else begin
      idf_code = IDF_NONE;
    end
  end

  assign interrupt_identification = {{2{fifo_enable_bit}}, 2'h0, idf_code};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      interrupt_output <= 1'b0;
    end else begin
      interrupt_output <= any_pend;
    end
  end

  // ********************************************************
  // assertions
  // ********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_rx_trig_int: assert property (
    fifo_enable_bit && interrupt_enable[IEN_RX] && !p_line
    && rx_count >= CW'(trig_bytes) |-> idf_code == IDF_RXAV)
    else $error("trigger level not reported");
  chk_line_prio: assert property (
    p_line |-> interrupt_identification[3:0] == IDF_LINE)
    else $error("line status not highest");
  chk_data_ready: assert property (
    avs_read && !acc && avs_address == OFS_LINE
    |=> avs_readdata[0] == ($past(rx_count) != '0))
    else $error("data ready wrong on status read");
  chk_timeout_read: assert property (
    rx_pop |=> !to_pend)
    else $error("timeout not cleared by read");
  chk_tx_holding_empty_write: assert property (
    tx_push && !tx_holding_empty_set |=> !tx_holding_empty_int)
    else $error("empty interrupt not cleared by write");
  chk_ien_upper: assert property (
    avs_read && !acc && avs_address == OFS_IEN
    |=> avs_readdata[31:4] == 28'h0)
    else $error("enable upper bits not zero");
  chk_idf_fifo_bits: assert property (
    avs_read && !acc && avs_address == OFS_IDF
    |=> avs_readdata[7:4] == {{2{$past(fifo_enable_bit)}}, 2'h0})
    else $error("ident high bits wrong");
  chk_int_out: assert property (
    any_pend |=> interrupt_output)
    else $error("interrupt output missing");
  chk_line_clear: assert property (
    rd_line && rx_err_event == 4'h0 |=> line_err == 4'h0)
    else $error("line errors not cleared");
  chk_polled_quiet: assert property (
    !interrupt_enable[IEN_RX] |-> ##1 !to_pend [*2])
    else $error("timeout in polled mode");
  chk_bus_answer: assert property (
    (avs_read || avs_write) && !acc |=> !avs_waitrequest)
    else $error("bus answer late");

  cov_timeout: cover property (p_to && idf_code == IDF_CTO);
  cov_tx_holding_empty: cover property (tx_holding_empty_set ##[1:50] tx_push);
  cov_line_over_rx: cover property (p_line && p_rx);
endmodule

// [sim/ufi_fifo_model.sv]
`timescale 1ns/1ns
module ufi_fifo_model
  import ufi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        rx_pop,
  input  wire logic        tx_push,
  input  wire logic        rx_fifo_clear,
  input  wire logic        tx_fifo_clear,
  input  wire logic        rx_in,
  input  wire logic        tx_pull,
  input  wire logic        rclk_run,
  output logic [CNT_W-1:0] rx_count,
  output logic [7:0]       rx_data,
  output logic             rx_push,
  output logic [CNT_W-1:0] tx_count,
  output logic             rclk_tick,
  output logic             tx_tick
);
  // ********************************************************
  // fifo occupancy and baud ticks seen by the block
  // ********************************************************
  assign rx_push = rx_in;
  assign rx_data = 8'hA0 + {3'h0, rx_count};
  always_ff @(posedge clk) begin
    if (!rst_b || rx_fifo_clear) begin
      rx_count <= '0;
    end else begin
      rx_count <= rx_count + {4'h0, rx_in}
        - {4'h0, rx_pop && rx_count != 5'h00};
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b || tx_fifo_clear) begin
      tx_count <= '0;
    end else begin
      tx_count <= tx_count + {4'h0, tx_push}
        - {4'h0, tx_pull && tx_count != 5'h00};
    end
  end
  // receive clock may stand still, transmit clock runs free
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rclk_tick <= 1'h0;
      tx_tick <= 1'h0;
    end else begin
      rclk_tick <= rclk_run && !rclk_tick;
      tx_tick <= !tx_tick;
    end
  end
endmodule

// [sim/tb_uart_fifo_interrupt_logic.sv]
`timescale 1ns/1ns
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", nm, e, s); end end
module tb_uart_fifo_interrupt_logic
  import ufi_pkg::*;
;
  logic             clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [4:0]       avs_address;
  logic [31:0]      avs_writedata, avs_readdata;
  logic [3:0]       avs_byteenable, rx_err_event, modem_pins;
  logic             rx_fifo_error, tx_shift_empty, two_stop, parity_en;
  logic [1:0]       word_len, trigger_level;
  logic [7:0]       tx_data;
  logic             fifo_enable_bit;
  logic [CNT_W-1:0] rx_count, tx_count;
  logic [7:0]       rx_data;
  logic             rx_push, rclk_tick, tx_tick, rx_pop, tx_push;
  logic             rx_fifo_clear, tx_fifo_clear, interrupt_output;
  logic             rx_in, tx_pull, rclk_run;
  logic [4:0]       lv [4];
  int               errors, compares;

  ufi_core dut_u (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_count(rx_count), .rx_data(rx_data), .rx_push(rx_push),
    .rx_err_event(rx_err_event), .rx_fifo_error(rx_fifo_error),
    .rclk_tick(rclk_tick), .tx_count(tx_count),
    .tx_shift_empty(tx_shift_empty), .tx_tick(tx_tick),
    .word_len(word_len), .two_stop(two_stop), .parity_en(parity_en),
    .modem_pins(modem_pins), .rx_pop(rx_pop), .tx_push(tx_push),
    .tx_data(tx_data), .fifo_enable_bit(fifo_enable_bit),
    .trigger_level(trigger_level),
    .rx_fifo_clear(rx_fifo_clear), .tx_fifo_clear(tx_fifo_clear),
    .interrupt_output(interrupt_output));
  ufi_fifo_model far_u (.clk(clk), .rst_b(rst_b), .rx_pop(rx_pop),
    .tx_push(tx_push), .rx_fifo_clear(rx_fifo_clear),
    .tx_fifo_clear(tx_fifo_clear), .rx_in(rx_in), .tx_pull(tx_pull),
    .rclk_run(rclk_run), .rx_count(rx_count), .rx_data(rx_data),
    .rx_push(rx_push), .tx_count(tx_count), .rclk_tick(rclk_tick),
    .tx_tick(tx_tick));

  // ********************************************************
  // bus and stimulus tasks
  // ********************************************************
  task automatic bus(input logic wr, input logic [4:0] a,
      input logic [7:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e,
      input string nm);
    logic [31:0] q;
    bus(1'h0, a, 8'h00, q);
    `CHK(nm, {24'h0, e}, q)
  endtask
  task automatic push(input int n);
    repeat (n) begin
      rx_in <= 1'h1;
      @(posedge clk);
      rx_in <= 1'h0;
      @(posedge clk);
    end
  endtask
  task automatic pulse_err(input logic [3:0] e);
    rx_err_event <= e;
    @(posedge clk);
    rx_err_event <= 4'h0;
    @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    print_verdict();
  end

  // ********************************************************
  // test sequence
  // ********************************************************
  initial begin
    {rst_b, avs_read, avs_write, rx_in, tx_pull} = '0;
    {avs_address, avs_writedata, rx_err_event, modem_pins} = '0;
    {rx_fifo_error, two_stop, parity_en} = '0;
    {rclk_run, tx_shift_empty} = 2'h3;
    avs_byteenable = 4'hF;
    word_len = 2'h3;
    lv = '{TRG_L0, TRG_L1, TRG_L2, TRG_L3};
    errors = 0;
    compares = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    rd(OFS_IEN, 8'h00, "enable");
    rd(OFS_IDF, 8'h01, "ident");
    rd(5'h0C, 8'h00, "unmapped");
    wr(OFS_IEN, 8'hFF);
    rd(OFS_IEN, 8'h0F, "enable");
    `CHK("irq", 1'h1, interrupt_output)
    rd(OFS_IDF, 8'h02, "ident");
    rd(OFS_IDF, 8'h01, "ident");
    `CHK("irq", 1'h0, interrupt_output)
    wr(OFS_IEN, 8'h01);
    wr(OFS_IDF, 8'h01);
    for (int t = 0; t < 4; t++) begin
      wr(OFS_IDF, {t[1:0], 6'h03});
      push(int'(lv[t]) - 1);
      rd(OFS_IDF, 8'hC1, "ident");
      push(1);
      rd(OFS_IDF, 8'hC4, "ident");
      `CHK("irq", 1'h1, interrupt_output)
      rd(OFS_DATA, 8'hA0 + {3'h0, lv[t]}, "data");
      rd(OFS_IDF, 8'hC1, "ident");
    end
    push(1);
    wr(OFS_IEN, 8'h05);
    for (int k = 0; k < 4; k++) begin
      pulse_err(4'h1 << k);
      rd(OFS_IDF, 8'hC6, "ident");
      rd(OFS_LINE, 8'h61 | (8'h02 << k), "line");
    end
    rd(OFS_IDF, 8'hC4, "ident");
    rd(OFS_LINE, 8'h61, "line");
    rx_fifo_error <= 1'h1;
    tx_shift_empty <= 1'h0;
    rd(OFS_LINE, 8'hA1, "line");
    rx_fifo_error <= 1'h0;
    tx_shift_empty <= 1'h1;
    wr(OFS_IDF, 8'hC3);
    rd(OFS_LINE, 8'h60, "line");
    wr(OFS_IEN, 8'h08);
    modem_pins <= 4'h1;
    repeat (8) @(posedge clk);
    rd(OFS_IDF, 8'hC0, "ident");
    rd(OFS_MDM, 8'h11, "modem");
    rd(OFS_IDF, 8'hC1, "ident");
    modem_pins <= 4'h0;
    repeat (8) @(posedge clk);
    wr(OFS_IEN, 8'h0A);
    rd(OFS_IDF, 8'hC2, "ident");
    rd(OFS_IDF, 8'hC0, "ident");
    rd(OFS_MDM, 8'h01, "modem");
    wr(OFS_DATA, 8'h55);
    `CHK("txd", 8'h55, tx_data)
    rd(OFS_IDF, 8'hC1, "ident");
    tx_pull <= 1'h1;
    @(posedge clk);
    tx_pull <= 1'h0;
    repeat (200) @(posedge clk);
    rd(OFS_IDF, 8'hC1, "ident");
    repeat (120) @(posedge clk);
    rd(OFS_IDF, 8'hC2, "ident");
    rd(OFS_IDF, 8'hC1, "ident");
    wr(OFS_IDF, 8'h00);
    `CHK("fen", 1'h0, fifo_enable_bit)
    rd(OFS_IDF, 8'h02, "ident");
    wr(OFS_IDF, 8'h01);
    rd(OFS_IDF, 8'hC2, "ident");
    wr(OFS_IEN, 8'h01);
    wr(OFS_IDF, 8'h47);
    `CHK("trig", 2'h1, trigger_level)
    `CHK("fen", 1'h1, fifo_enable_bit)
    two_stop <= 1'h1;
    push(2);
    repeat (1370) @(posedge clk);
    rd(OFS_IDF, 8'hC1, "ident");
    repeat (60) @(posedge clk);
    rd(OFS_IDF, 8'hCC, "ident");
    `CHK("irq", 1'h1, interrupt_output)
    rd(OFS_DATA, 8'hA2, "data");
    rd(OFS_IDF, 8'hC1, "ident");
    repeat (1000) @(posedge clk);
    push(1);
    repeat (1000) @(posedge clk);
    rd(OFS_IDF, 8'hC1, "ident");
    repeat (500) @(posedge clk);
    rd(OFS_IDF, 8'hCC, "ident");
    rd(OFS_DATA, 8'hA2, "data");
    rclk_run <= 1'h0;
    repeat (2000) @(posedge clk);
    rd(OFS_IDF, 8'hC1, "ident");
    rclk_run <= 1'h1;
    repeat (1450) @(posedge clk);
    rd(OFS_IDF, 8'hCC, "ident");
    wr(OFS_IEN, 8'h00);
    rd(OFS_IDF, 8'hC1, "ident");
    `CHK("irq", 1'h0, interrupt_output)
    rd(OFS_LINE, 8'h61, "line");
    wr(OFS_IEN, 8'h02);
    rd(OFS_IDF, 8'hC2, "ident");
    print_verdict();
  end
endmodule
